/* File: src/pllbc_consts.svh */
`ifndef PLLBC_CONSTS_SVH
`define PLLBC_CONSTS_SVH

// Reset images of the three control bytes.
`define PLLBC_CTL_RESET      8'h2F
`define PLLBC_BW_RESET       8'h00
`define PLLBC_MUL_RESET      8'h66

// Unimplemented low nibble of the loop control byte reads as ones.
`define PLLBC_CTL_LOW_ONES   4'hF

// Source clock cycles counted on each side during a base source change.
`define PLLBC_XFER_CYCLES    2'h3

// Range factor value that disables the loop.
`define PLLBC_RANGE_OFF      4'h0

// Feedback factor value that acts as one, and its substitute.
`define PLLBC_FB_ZERO        4'h0
`define PLLBC_FB_ONE         4'h1

`endif

/* File: src/pllbc_pkg.sv */
package pllbc_pkg;

    // Loop control byte image, bit 7 down to bit 0.
    typedef struct packed {
        logic       lock_change_irq_enable;
        logic       lock_change_flag;
        logic       loop_power_on;
        logic       base_source_select;
        logic [3:0] unused;
    } pllbc_ctl_t;

    // Bandwidth control byte image, bit 7 down to bit 0.
    typedef struct packed {
        logic       auto_bandwidth;
        logic       lock;
        logic       filter_track_select;
        logic       spare;
        logic [3:0] unused;
    } pllbc_bw_t;

    // Loop multiplier byte image.
    typedef struct packed {
        logic [3:0] feedback_factor;
        logic [3:0] range_factor;
    } pllbc_mul_t;

    // Lock detector tolerance reports from the analog loop.
    typedef struct packed {
        logic in_lock_tol;
        logic out_unlock_tol;
        logic in_track_tol;
        logic out_untrack_tol;
    } pllbc_tol_t;

    typedef enum logic [1:0] {
        PLLBC_RUN,
        PLLBC_HOLD
    } pllbc_xfer_t;

endpackage : pllbc_pkg

/* File: src/pllbc_sync.sv */
`timescale 1ns/10ps

module pllbc_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Asynchronous input
    input  wire logic async_in,
    // Filtered level and its rising edge
    output logic      level,
    output logic      rise
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic rise_reg;
    logic level_next;
    logic rise_next;

    // A change is accepted only when the second and third stages agree.
    always_comb begin
        level_next = level_reg;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
        rise_next = level_next & ~level_reg;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            s3_reg    <= 1'b0;
            level_reg <= 1'b0;
            rise_reg  <= 1'b0;
        end else begin
            s1_reg    <= async_in;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
            rise_reg  <= rise_next;
        end
    end

    assign level = level_reg;
    assign rise  = rise_reg;

endmodule : pllbc_sync

/* File: src/pllbc_top.sv */
// Summary of operation
// - Self-control mode lets the lock detector switch acquisition and tracking itself.
// - In self-control the track bit is read-only and shows the filter mode.
// - Track sets entering tracking tolerance, clears leaving wider untrack tolerance.
// - In self-control the lock bit is a read-only lock report.
// - Lock sets within lock tolerance, clears beyond the unlock tolerance.
// - With interrupt enable set, every lock toggle requests an interrupt.
// - In manual mode the track bit is written directly; one selects tracking.
// - Manual mode disables the lock indicator and all loop interrupts.
// - Upper multiplier nibble is the feedback divide factor.
// - Lower multiplier nibble is the linear range factor.
// - A feedback factor of zero acts as one.
// - Range factor zero disables the loop and forces the crystal source.
// - A change to the VCO waits three cycles of each clock, a return to the crystal three crystal cycles, output held still.
// - Transition output is halved for a 50 percent duty base clock.
// - The base source select bit picks crystal or VCO clock.
// - No VCO select while loop off; no loop off while VCO selected.
// - One write cannot both change loop power and change source select.
// - Select one means VCO halved, zero crystal halved; reset selects zero.
// - Flag sets on each lock toggle, reads zero in manual, read clears.
// - In manual mode the interrupt enable is unwritable, reads zero; reset clears.
// - Reset sets loop power on so the loop settles during power-up.
`timescale 1ns/10ps

`include "pllbc_consts.svh"

module pllbc_top (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 nrst,
    // Source clocks, asynchronous
    input  wire logic                 crystal_clock,
    input  wire logic                 vco_clock,
    // Lock detector reports, asynchronous
    input  wire pllbc_pkg::pllbc_tol_t tol_in,
    // Loop control byte access
    input  wire logic                 ctl_wr,
    input  wire pllbc_pkg::pllbc_ctl_t ctl_wdata,
    input  wire logic                 ctl_rd,
    output pllbc_pkg::pllbc_ctl_t     loop_control_reg,
    // Bandwidth control byte access
    input  wire logic                 bw_wr,
    input  wire pllbc_pkg::pllbc_bw_t  bw_wdata,
    output pllbc_pkg::pllbc_bw_t      bw_rdata,
    // Loop multiplier byte access
    input  wire logic                 mul_wr,
    input  wire pllbc_pkg::pllbc_mul_t mul_wdata,
    output pllbc_pkg::pllbc_mul_t     loop_multiplier_reg,
    // Analog loop controls
    output logic                      loop_enable,
    output logic                      filter_track_mode,
    output logic [3:0]                feedback_divide,
    output logic [3:0]                range_factor,
    // Clock and interrupt outputs
    output logic                      base_clock_out,
    output logic                      base_switching,
    output logic                      lock_irq_request
);

    import pllbc_pkg::*;

    // Synchronised views of every asynchronous input.
    logic       xtal_level;
    logic       xtal_rise;
    logic       vco_level;
    logic       vco_rise;
    logic [3:0] tol_raw;
    logic [3:0] tol_sync;
    pllbc_tol_t tol;

    assign tol_raw = tol_in;
    assign tol     = tol_sync;

    pllbc_sync u_sync_xtal (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (crystal_clock),
        .level    (xtal_level),
        .rise     (xtal_rise)
    );

    pllbc_sync u_sync_vco (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (vco_clock),
        .level    (vco_level),
        .rise     (vco_rise)
    );

    // The tolerance reports come from the loop domain.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_tol
            pllbc_sync u_sync_tol (
                .clock    (clock),
                .nrst     (nrst),
                .async_in (tol_raw[gi]),
                .level    (tol_sync[gi]),
                .rise     ()
            );
        end
    endgenerate

    // Control and status state; the reset images are constants so reset loads fixed values.
    localparam pllbc_ctl_t ctl_reset_img = `PLLBC_CTL_RESET;
    localparam pllbc_bw_t  bw_reset_img  = `PLLBC_BW_RESET;
    localparam pllbc_mul_t mul_reset_img = `PLLBC_MUL_RESET;

    logic       irq_en_reg;
    logic       irq_en_next;
    logic       flag_reg;
    logic       flag_next;
    logic       power_reg;
    logic       power_next;
    logic       sel_reg;
    logic       sel_next;
    logic       auto_reg;
    logic       auto_next;
    logic       lock_reg;
    logic       lock_next;
    logic       track_reg;
    logic       track_next;
    logic       spare_reg;
    logic       spare_next;
    pllbc_mul_t mul_reg;
    pllbc_mul_t mul_next;
    logic       range_ok;
    logic       power_change;

    assign range_ok = (mul_reg.range_factor != `PLLBC_RANGE_OFF);

    always_comb begin
        irq_en_next  = irq_en_reg;
        flag_next    = flag_reg;
        power_next   = power_reg;
        sel_next     = sel_reg;
        auto_next    = auto_reg;
        lock_next    = lock_reg;
        track_next   = track_reg;
        spare_next   = spare_reg;
        mul_next     = mul_reg;
        power_change = 1'b0;

        if (bw_wr) begin
            auto_next  = bw_wdata.auto_bandwidth;
            spare_next = bw_wdata.spare;
            if (!auto_reg) begin
                track_next = bw_wdata.filter_track_select;
            end
        end

        // The multiplier is frozen while the loop runs.
        if (mul_wr && !power_reg) begin
            mul_next = mul_wdata;
        end

        if (ctl_wr) begin
            if (auto_reg) begin
                irq_en_next = ctl_wdata.lock_change_irq_enable;
            end
            // Power may only be dropped once the crystal is the source.
            if (!sel_reg) begin
                power_next = ctl_wdata.loop_power_on;
            end
            power_change = (power_next != power_reg);
            // A write that moves power leaves the source select alone.
            if (!power_change) begin
                sel_next = ctl_wdata.base_source_select;
            end
        end

        // The VCO cannot be selected with the loop off or the range at zero.
        if (!power_reg || !range_ok) begin
            sel_next = 1'b0;
        end

        // Self-control: hysteresis between the set and the clear tolerances.
        if (auto_reg) begin
            if (tol.in_track_tol) begin
                track_next = 1'b1;
            end else if (tol.out_untrack_tol) begin
                track_next = 1'b0;
            end
            if (tol.in_lock_tol) begin
                lock_next = 1'b1;
            end else if (tol.out_unlock_tol) begin
                lock_next = 1'b0;
            end
        end else begin
            lock_next = 1'b0;
        end

        // A toggle in the same cycle as the clearing read still sets the flag.
        if (ctl_rd) begin
            flag_next = 1'b0;
        end
        if (auto_reg && (lock_next != lock_reg)) begin
            flag_next = 1'b1;
        end

        if (!auto_next) begin
            irq_en_next = 1'b0;
            flag_next   = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_en_reg <= ctl_reset_img.lock_change_irq_enable;
            flag_reg   <= ctl_reset_img.lock_change_flag;
            power_reg  <= ctl_reset_img.loop_power_on;
            sel_reg    <= ctl_reset_img.base_source_select;
            auto_reg   <= bw_reset_img.auto_bandwidth;
            lock_reg   <= bw_reset_img.lock;
            track_reg  <= bw_reset_img.filter_track_select;
            spare_reg  <= bw_reset_img.spare;
            mul_reg    <= mul_reset_img;
        end else begin
            irq_en_reg <= irq_en_next;
            flag_reg   <= flag_next;
            power_reg  <= power_next;
            sel_reg    <= sel_next;
            auto_reg   <= auto_next;
            lock_reg   <= lock_next;
            track_reg  <= track_next;
            spare_reg  <= spare_next;
            mul_reg    <= mul_next;
        end
    end

    // Read images come from the state flops, with the enable, flag and lock bits masked by self-control.
    always_comb begin
        loop_control_reg.lock_change_irq_enable = irq_en_reg & auto_reg;
        loop_control_reg.lock_change_flag       = flag_reg & auto_reg;
        loop_control_reg.loop_power_on          = power_reg;
        loop_control_reg.base_source_select     = sel_reg;
        loop_control_reg.unused                 = `PLLBC_CTL_LOW_ONES;
        bw_rdata.auto_bandwidth                 = auto_reg;
        bw_rdata.lock                           = lock_reg & auto_reg;
        bw_rdata.filter_track_select            = track_reg;
        bw_rdata.spare                          = spare_reg;
        bw_rdata.unused                         = 4'h0;
        loop_multiplier_reg                     = mul_reg;
    end

    assign lock_irq_request  = irq_en_reg & flag_reg & auto_reg;
    assign loop_enable       = power_reg & range_ok;
    assign filter_track_mode = track_reg;
    assign range_factor      = mul_reg.range_factor;
    assign feedback_divide   = (mul_reg.feedback_factor == `PLLBC_FB_ZERO) ?
                               `PLLBC_FB_ONE : mul_reg.feedback_factor;

    // Base clock selector.
    // The output toggles on each rising edge of the active source, which
    // halves it with a clean 50 percent duty whatever the source duty is.
    // During a change the output is frozen until the crystal, and the VCO too
    // when it is selected, has shown its cycles, so no runt pulse can reach the clock consumer.
    pllbc_xfer_t xfer_reg;
    pllbc_xfer_t xfer_next;
    logic        active_reg;
    logic        active_next;
    logic [1:0]  xcnt_reg;
    logic [1:0]  xcnt_next;
    logic [1:0]  vcnt_reg;
    logic [1:0]  vcnt_next;
    logic        out_reg;
    logic        out_next;
    logic        src_rise;

    assign src_rise = active_reg ? vco_rise : xtal_rise;

    always_comb begin
        xfer_next   = xfer_reg;
        active_next = active_reg;
        xcnt_next   = xcnt_reg;
        vcnt_next   = vcnt_reg;
        out_next    = out_reg;
        case (xfer_reg)
            PLLBC_RUN: begin
                if (sel_reg != active_reg) begin
                    xfer_next = PLLBC_HOLD;
                    xcnt_next = 2'h0;
                    vcnt_next = 2'h0;
                end else if (src_rise) begin
                    out_next = ~out_reg;
                end
            end
            PLLBC_HOLD: begin
                if (xtal_rise && (xcnt_reg != `PLLBC_XFER_CYCLES)) begin
                    xcnt_next = xcnt_reg + 2'h1;
                end
                if (vco_rise && (vcnt_reg != `PLLBC_XFER_CYCLES)) begin
                    vcnt_next = vcnt_reg + 2'h1;
                end
                // A dead VCO must not trap a return to the crystal.
                if ((xcnt_reg == `PLLBC_XFER_CYCLES) &&
                    ((vcnt_reg == `PLLBC_XFER_CYCLES) || !sel_reg)) begin
                    active_next = sel_reg;
                    xfer_next   = PLLBC_RUN;
                end
            end
            default: begin
                xfer_next   = PLLBC_RUN;
                active_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            xfer_reg   <= PLLBC_RUN;
            active_reg <= 1'b0;
            xcnt_reg   <= 2'h0;
            vcnt_reg   <= 2'h0;
            out_reg    <= 1'b0;
        end else begin
            xfer_reg   <= xfer_next;
            active_reg <= active_next;
            xcnt_reg   <= xcnt_next;
            vcnt_reg   <= vcnt_next;
            out_reg    <= out_next;
        end
    end

    assign base_clock_out = out_reg;
    assign base_switching = (xfer_reg == PLLBC_HOLD);

endmodule : pllbc_top

/* File: testbench/pllbc_top_assertions.sv */
`timescale 1ns/10ps

module pllbc_top_assertions (
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  nrst,
    // Register access
    input wire logic                  ctl_wr,
    input wire pllbc_pkg::pllbc_ctl_t ctl_wdata,
    input wire pllbc_pkg::pllbc_ctl_t loop_control_reg,
    input wire pllbc_pkg::pllbc_bw_t  bw_rdata,
    input wire pllbc_pkg::pllbc_mul_t loop_multiplier_reg,
    // Loop controls and outputs
    input wire logic                  loop_enable,
    input wire logic                  filter_track_mode,
    input wire logic [3:0]            feedback_divide,
    input wire logic [3:0]            range_factor,
    input wire logic                  base_clock_out,
    input wire logic                  base_switching,
    input wire logic                  lock_irq_request
);
    import pllbc_pkg::*;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // Source periods are several system cycles, so a change that lands sooner is a fault.
    sequence base_quiet;
        $stable(base_clock_out) [*4];
    endsequence

    sequence switch_done;
        ##[1:150] !base_switching;
    endsequence

    chk_irq_level: assert property (lock_irq_request == (bw_rdata.auto_bandwidth
        && loop_control_reg.lock_change_irq_enable && loop_control_reg.lock_change_flag))
        else $error("interrupt request does not follow enable and flag");
    chk_manual_quiet: assert property (!bw_rdata.auto_bandwidth |-> !bw_rdata.lock
        && !loop_control_reg.lock_change_flag && !loop_control_reg.lock_change_irq_enable)
        else $error("lock status visible in manual mode");
    chk_toggle_flags: assert property (bw_rdata.auto_bandwidth && $past(bw_rdata.auto_bandwidth)
        && $changed(bw_rdata.lock) |-> loop_control_reg.lock_change_flag)
        else $error("lock toggle did not set the flag");
    chk_sel_guard: assert property (loop_control_reg.base_source_select |->
        loop_control_reg.loop_power_on && range_factor != 4'h0)
        else $error("vco source selected with loop off");
    chk_one_change: assert property (ctl_wr && !loop_control_reg.base_source_select
        && ctl_wdata.loop_power_on != loop_control_reg.loop_power_on
        |=> !loop_control_reg.base_source_select)
        else $error("power and source changed together");
    chk_mul_locked: assert property (loop_control_reg.loop_power_on |=>
        $stable(loop_multiplier_reg)) else $error("multiplier changed with loop on");
    chk_fb_zero: assert property (feedback_divide ==
        ((loop_multiplier_reg.feedback_factor == 4'h0) ? 4'h1
        : loop_multiplier_reg.feedback_factor)) else $error("feedback factor wrong");
    chk_range_off: assert property (loop_enable == (loop_control_reg.loop_power_on
        && loop_multiplier_reg.range_factor != 4'h0 && range_factor
        == loop_multiplier_reg.range_factor)) else $error("loop enable wrong");
    chk_track_out: assert property (filter_track_mode == bw_rdata.filter_track_select)
        else $error("filter mode differs from track bit");
    chk_switch_start: assert property ($rose(loop_control_reg.base_source_select)
        && !base_switching |=> base_switching) else $error("source change not started");
    chk_switch_ends: assert property ($rose(base_switching) |-> switch_done)
        else $error("source change never ended");
    chk_hold_still: assert property ($past(base_switching) && base_switching |->
        $stable(base_clock_out)) else $error("base clock moved during change");
    chk_half_rate: assert property ($changed(base_clock_out) |=> base_quiet)
        else $error("base clock toggled too fast");
endmodule : pllbc_top_assertions

bind pllbc_top pllbc_top_assertions u_chk (.clock, .nrst, .ctl_wr, .ctl_wdata,
    .loop_control_reg, .bw_rdata, .loop_multiplier_reg, .loop_enable, .filter_track_mode,
    .feedback_divide, .range_factor, .base_clock_out, .base_switching, .lock_irq_request);

/* File: testbench/pllbc_src_model.sv */
`timescale 1ns/10ps

module pllbc_src_model (
    // Loop state and commanded tolerance reports
    input  wire logic                  vco_run,
    input  wire pllbc_pkg::pllbc_tol_t tol_cmd,
    // Source clocks and lock detector reports
    output logic                       crystal_clock,
    output logic                       vco_clock,
    output pllbc_pkg::pllbc_tol_t      tol_in
);
    import pllbc_pkg::*;

    // Both sources sit off the system clock grid, so no source edge races a sampling edge.
    initial begin
        crystal_clock = 1'b0;
        #1;
        forever #60 crystal_clock = ~crystal_clock;
    end

    // An unpowered oscillator stands still rather than running free.
    initial begin
        vco_clock = 1'b0;
        #2;
        forever begin
            #36;
            vco_clock = vco_run ? ~vco_clock : 1'b0;
        end
    end

    assign tol_in = tol_cmd;
endmodule : pllbc_src_model

/* File: testbench/tb_pll_bandwidth_and_base_clock_select.sv */
`timescale 1ns/10ps

module tb_pll_bandwidth_and_base_clock_select;
    import pllbc_pkg::*;

    logic       clock, nrst, ctl_wr, ctl_rd, bw_wr, mul_wr;
    logic       crystal_clock, vco_clock, loop_enable, filter_track_mode;
    logic       base_clock_out, base_switching, lock_irq_request;
    logic [3:0] feedback_divide, range_factor;
    pllbc_ctl_t ctl_wdata, loop_control_reg;
    pllbc_bw_t  bw_wdata, bw_rdata;
    pllbc_mul_t mul_wdata, loop_multiplier_reg;
    pllbc_tol_t tol_cmd, tol_in;
    int         bad_count, compares, cycles, n;
    logic [7:0] v;

    pllbc_top dut (.clock, .nrst, .crystal_clock, .vco_clock, .tol_in, .ctl_wr, .ctl_wdata,
        .ctl_rd, .loop_control_reg, .bw_wr, .bw_wdata, .bw_rdata, .mul_wr, .mul_wdata,
        .loop_multiplier_reg, .loop_enable, .filter_track_mode, .feedback_divide,
        .range_factor, .base_clock_out, .base_switching, .lock_irq_request);

    pllbc_src_model u_src (.vco_run(loop_enable), .tol_cmd, .crystal_clock, .vco_clock,
        .tol_in);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // Which byte: 0 loop control, 1 bandwidth, 2 multiplier.
    task automatic put(input int which, input logic [7:0] d);
        @(posedge clock);
        ctl_wr    <= (which == 0);
        bw_wr     <= (which == 1);
        mul_wr    <= (which == 2);
        ctl_wdata <= d;
        bw_wdata  <= d;
        mul_wdata <= d;
        @(posedge clock);
        ctl_wr <= 1'b0;
        bw_wr  <= 1'b0;
        mul_wr <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask : put

    // The image is captured before the read strobe clears the flag.
    task automatic get_ctl(output logic [7:0] d);
        d = loop_control_reg;
        @(posedge clock);
        ctl_rd <= 1'b1;
        @(posedge clock);
        ctl_rd <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask : get_ctl

    task automatic settle(input logic [3:0] t);
        @(posedge clock);
        tol_cmd <= t;
        repeat (12) @(posedge clock);
        #1;
    endtask : settle

    // Cycles between two successive base clock edges, after a change is over.
    task automatic meas(output int cnt);
        logic b;
        cnt = 0;
        while (base_switching === 1'b1 && cnt < 200) begin
            @(posedge clock);
            #1;
            cnt++;
        end
        repeat (2) begin
            b = base_clock_out;
            cnt = 0;
            while (base_clock_out === b && cnt < 40) begin
                @(posedge clock);
                #1;
                cnt++;
            end
        end
    endtask : meas

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        {nrst, ctl_wr, ctl_rd, bw_wr, mul_wr} = 5'h00;
        {ctl_wdata, bw_wdata, mul_wdata, tol_cmd} = 28'h0;
        {bad_count, compares, cycles} = 0;
        repeat (20) @(posedge clock);
        #1;
        check(loop_control_reg, 8'h2F);
        check(bw_rdata, 8'h00);
        check(loop_multiplier_reg, 8'h66);
        check({loop_enable, base_switching, feedback_divide}, 8'h26);
        @(posedge clock) nrst <= 1'b1;
        put(2, 8'h35);
        check(loop_multiplier_reg, 8'h66);
        put(0, 8'h00);
        check({loop_control_reg, 7'h00, loop_enable}, 16'h0F00);
        put(2, 8'h07);
        check({feedback_divide, range_factor}, 8'h17);
        put(2, 8'h80);
        put(0, 8'h20);
        put(0, 8'h30);
        check({loop_control_reg, 7'h00, loop_enable}, 16'h2F00);
        put(0, 8'h00);
        put(2, 8'h87);
        check({feedback_divide, range_factor}, 8'h87);
        put(1, 8'h00);
        put(0, 8'h30);
        check({loop_control_reg, 7'h00, loop_enable}, 16'h2F01);
        repeat (40) @(posedge clock);
        put(1, 8'h20);
        check({bw_rdata, 7'h00, filter_track_mode}, 16'h2001);
        repeat (40) @(posedge clock);
        put(0, 8'h30);
        check(loop_control_reg, 8'h3F);
        meas(n);
        check(8'(n >= 8 && n <= 10), 8'h01);
        put(0, 8'h10);
        check(loop_control_reg, 8'h3F);
        put(0, 8'h20);
        check(loop_control_reg, 8'h2F);
        meas(n);
        check(8'(n >= 14 && n <= 16), 8'h01);
        settle(4'h8);
        put(0, 8'hA0);
        check({loop_control_reg, bw_rdata, 7'h00, lock_irq_request}, 24'h2F2000);
        put(1, 8'h00);
        settle(4'h0);
        put(1, 8'h80);
        put(0, 8'hA0);
        check({loop_control_reg, bw_rdata}, 16'hAF80);
        settle(4'h2);
        check({bw_rdata, 7'h00, filter_track_mode}, 16'hA001);
        put(1, 8'h80);
        check(bw_rdata, 8'hA0);
        settle(4'h0);
        check(bw_rdata, 8'hA0);
        settle(4'h8);
        check({bw_rdata, 7'h00, lock_irq_request}, 16'hE001);
        get_ctl(v);
        check(v, 8'hEF);
        check({loop_control_reg, 7'h00, lock_irq_request}, 16'hAF00);
        settle(4'h5);
        check({bw_rdata, loop_control_reg}, 16'h80EF);
        check({7'h00, lock_irq_request}, 8'h01);
        put(1, 8'h00);
        check({loop_control_reg, 7'h00, lock_irq_request}, 16'h2F00);
        give_verdict();
    end
endmodule : tb_pll_bandwidth_and_base_clock_select
